// ---- logic/meir_consts.vh ----
// register offsets, field positions, reset values and timing counts
// for the motion event timing and interrupt routing block
// assumes a byte-wide register port and a 50 MHz system clock
`ifndef MEIR_CONSTS_VH
`define MEIR_CONSTS_VH

// register offsets (byte addresses on the register port)
`define MEIR_ADDR_DUR        8'h5C
`define MEIR_ADDR_FALL       8'h5D
`define MEIR_ADDR_P1         8'h5E
`define MEIR_ADDR_P2         8'h5F

// reset values
`define MEIR_RST_DUR         8'h00
`define MEIR_RST_FALL        8'h00
`define MEIR_RST_ROUTE       8'h00

// duration register fields
`define MEIR_DUR_FALL_MSB    7
`define MEIR_DUR_WAKE_HI     6
`define MEIR_DUR_WAKE_LO     5
`define MEIR_DUR_WEIGHT      4
`define MEIR_DUR_SLEEP_HI    3
`define MEIR_DUR_SLEEP_LO    0

// free-fall register fields
`define MEIR_FALL_TIME_HI    7
`define MEIR_FALL_TIME_LO    3
`define MEIR_FALL_CODE_HI    2
`define MEIR_FALL_CODE_LO    0

// routing register bit positions, shared by both pins except bit 0
`define MEIR_RT_ACTIVITY     7
`define MEIR_RT_SINGLE       6
`define MEIR_RT_WAKEUP       5
`define MEIR_RT_FALL         4
`define MEIR_RT_DOUBLE       3
`define MEIR_RT_ORIENT       2
`define MEIR_RT_EMBED        1
`define MEIR_RT_LAST         0

// sleep entry timing in sample periods
`define MEIR_SLEEP_DEFAULT   16'h0010
`define MEIR_SLEEP_UNIT      16'h0200

// wakeup level scaling shifts: full scale over 2^6 or 2^8
`define MEIR_WK_SHIFT_COARSE 6
`define MEIR_WK_SHIFT_FINE   8

// early overflow alert lead time
`define MEIR_TS_LEAD_US      6400
`define MEIR_CLK_MHZ         50
`define MEIR_TS_LEAD_CYC     (`MEIR_TS_LEAD_US * `MEIR_CLK_MHZ)

`endif

// ---- logic/meir_top.v ----
// motion event duration counters, threshold weighting and interrupt routing
// assumes sample_tick pulses once per accelerometer output sample and
// event and condition inputs are synchronous to clock
// register port is a one-cycle strobe interface with a registered ack
// pins are active-high levels; latching and polarity live elsewhere
// the detectors that raise fall_cond, wake_cond and still_cond compare
// samples against the thresholds reported here; this block only times them
`timescale 1ns/1ps
`include "meir_consts.vh"

module meir_top (
   input  wire        clock,
   input  wire        sys_rst,
   input  wire        reg_wr,
   input  wire        reg_rd,
   input  wire [7:0]  reg_addr,
   input  wire [7:0]  reg_wdata,
   output reg  [7:0]  reg_rdata_ff,
   output reg         reg_ack_ff,
   input  wire        sample_tick,
   input  wire        basic_irq_enable,
   input  wire        sleep_status_on_irq,
   input  wire [5:0]  wakeup_level,
   input  wire [2:0]  accel_full_scale,
   input  wire        fall_cond,
   input  wire        wake_cond,
   input  wire        still_cond,
   input  wire        single_knock_evt,
   input  wire        double_knock_evt,
   input  wire        orientation_evt,
   input  wire        embedded_evt,
   input  wire        hub_done_evt,
   input  wire [31:0] ts_count,
   output reg         irq_pin_one_ff,
   output reg         irq_pin_two_ff,
   output reg         fall_evt_ff,
   output reg         wake_evt_ff,
   output reg         asleep_ff,
   output reg  [8:0]  fall_level_mg_ff,
   output reg  [15:0] wake_level_mg_ff
);

   // register storage
   reg [7:0]  dur_cfg_ff;                 // motion_duration_config
   reg [7:0]  fall_cfg_ff;                // freefall_config
   reg [7:0]  p1_route_ff;                // irq_pin1_routing
   reg [7:0]  p2_route_ff;                // irq_pin2_routing
   reg [7:0]  nxt_rdata;

   // counters, one tick per sample period
   // widths cover the largest programmable count of each timer
   reg [5:0]  fall_cnt_ff;                // free-fall samples so far
   reg [2:0]  wake_cnt_ff;                // wakeup samples so far
   // 13 bits hold fifteen times 512 periods without wrapping
   reg [12:0] still_cnt_ff;               // stillness samples so far
   reg        sleep_chg_ff;               // one-cycle sleep state change
   // registered so the wide compare does not sit in the pin path
   reg        ts_alert_ff;                // early overflow alert

   // decoded configuration fields
   wire [5:0]  fall_time;
   wire [1:0]  wakeup_time;
   wire        wakeup_level_weight;
   wire [3:0]  sleep_entry_time;
   wire [2:0]  fall_level_code;
   wire [12:0] sleep_target;
   wire        activity_evt;
   wire [7:0]  p1_events;
   wire [7:0]  p2_events;
   wire        ts_near_wrap;
   wire [15:0] sleep_target_w;            // full-width product before the cut
   wire [7:0]  p1_gated;                  // pin one events that are routed
   wire [7:0]  p2_gated;                  // pin two events that are routed
   wire [15:0] level_ext;                 // wakeup level widened for the product

   // loop index for the per-bit routing gates
   genvar      gi;

   // fs in g: code 0..3 maps 2,4,8,16 g
   wire [15:0] fs_mg;

   assign fall_time           = {dur_cfg_ff[`MEIR_DUR_FALL_MSB],
                                 fall_cfg_ff[`MEIR_FALL_TIME_HI:`MEIR_FALL_TIME_LO]};
   assign wakeup_time         = dur_cfg_ff[`MEIR_DUR_WAKE_HI:`MEIR_DUR_WAKE_LO];
   assign wakeup_level_weight = dur_cfg_ff[`MEIR_DUR_WEIGHT];
   assign sleep_entry_time    = dur_cfg_ff[`MEIR_DUR_SLEEP_HI:`MEIR_DUR_SLEEP_LO];
   assign fall_level_code     = fall_cfg_ff[`MEIR_FALL_CODE_HI:`MEIR_FALL_CODE_LO];

   // zero means the short default, otherwise 512 periods per count
   // product is formed at 16 bits, then cut; the largest value fits 13
   // a zero setting must not give a zero target, or sleep would be instant
   assign sleep_target_w = (sleep_entry_time == 4'h0) ?
                           `MEIR_SLEEP_DEFAULT :
                           ({12'h000, sleep_entry_time} * `MEIR_SLEEP_UNIT);
   assign sleep_target   = sleep_target_w[12:0];

   // change mode pulses on transitions, status mode shows the state
   // the result feeds bit 7 of both routing vectors
   assign activity_evt = sleep_status_on_irq ? asleep_ff : sleep_chg_ff;

   // full scale in mg; the top code bit is ignored by this block,
   // so only 2, 4, 8 and 16 g are decoded
   assign fs_mg     = 16'd2000 << accel_full_scale[1:0];
   // widened on purpose so the product keeps all sixteen bits
   assign level_ext = {10'h000, wakeup_level};

   // free-fall threshold table in mg
   // eight codes, eight steps; the last code is also the fallback
   function [8:0] fall_mg;
      input [2:0] code;
      begin
         case (code)
            3'h0: fall_mg = 9'd156;
            3'h1: fall_mg = 9'd219;
            3'h2: fall_mg = 9'd250;
            3'h3: fall_mg = 9'd312;
            3'h4: fall_mg = 9'd344;
            3'h5: fall_mg = 9'd406;
            3'h6: fall_mg = 9'd469;
            default: fall_mg = 9'd500;
         endcase
      end
   endfunction

   // address hit test, used by read and write paths
   // one function so read and write decode can never disagree
   function hit;
      input [7:0] a;
      input [7:0] b;
      begin
         hit = (a == b);
      end
   endfunction

   // alert window: the top lead count before the counter wraps
   // the bound is a constant, so no subtraction is built at run time
   // the alert stays high until the counter wraps back to zero
   assign ts_near_wrap = (ts_count >= (32'hFFFF_FFFF - `MEIR_TS_LEAD_CYC));

   // event vectors in routing bit order; basic events need global enable
   // embedded and hub events bypass the global enable on purpose
   // pin two shares bits 7:1 and swaps in the overflow alert at bit 0
   assign p1_events = {activity_evt     & basic_irq_enable,
                       single_knock_evt & basic_irq_enable,
                       wake_evt_ff      & basic_irq_enable,
                       fall_evt_ff      & basic_irq_enable,
                       double_knock_evt & basic_irq_enable,
                       orientation_evt  & basic_irq_enable,
                       embedded_evt,
                       hub_done_evt};
   assign p2_events = {p1_events[7:1], ts_alert_ff};

   // register writes; reset gives all fields zero
   // writes to unmapped offsets fall through and change nothing
   // all four registers are plain read/write bytes with no side effects
   always @(posedge clock) begin
      if (sys_rst) begin
         dur_cfg_ff  <= `MEIR_RST_DUR;
         fall_cfg_ff <= `MEIR_RST_FALL;
         p1_route_ff <= `MEIR_RST_ROUTE;
         p2_route_ff <= `MEIR_RST_ROUTE;
      end else if (reg_wr) begin
         if (hit(reg_addr, `MEIR_ADDR_DUR))
            dur_cfg_ff <= reg_wdata;
         if (hit(reg_addr, `MEIR_ADDR_FALL))
            fall_cfg_ff <= reg_wdata;
         if (hit(reg_addr, `MEIR_ADDR_P1))
            p1_route_ff <= reg_wdata;
         if (hit(reg_addr, `MEIR_ADDR_P2))
            p2_route_ff <= reg_wdata;
      end
   end

   // read mux; unmapped addresses read zero
   // combinational, sampled only when a read strobe is present
   always @* begin
      nxt_rdata = 8'h00;
      if (hit(reg_addr, `MEIR_ADDR_DUR))
         nxt_rdata = dur_cfg_ff;
      else if (hit(reg_addr, `MEIR_ADDR_FALL))
         nxt_rdata = fall_cfg_ff;
      else if (hit(reg_addr, `MEIR_ADDR_P1))
         nxt_rdata = p1_route_ff;
      else if (hit(reg_addr, `MEIR_ADDR_P2))
         nxt_rdata = p2_route_ff;
   end

   // read data registered; ack one cycle after any access
   // ack also answers unmapped offsets so a host never stalls
   // read data holds between reads, so a slow host may sample late
   always @(posedge clock) begin
      if (sys_rst) begin
         reg_rdata_ff <= 8'h00;
         reg_ack_ff   <= 1'b0;
      end else begin
         reg_ack_ff <= reg_wr | reg_rd;
         if (reg_rd) begin
            reg_rdata_ff <= nxt_rdata;
         end
      end
   end

   // free-fall duration: count samples while low-g holds
   // counter stops at the setting; the event stays until the condition lapses
   // a zero setting fires on the first sample of the condition
   always @(posedge clock) begin
      if (sys_rst) begin
         fall_cnt_ff <= 6'h00;
         fall_evt_ff <= 1'b0;
      end else if (!fall_cond) begin
         // condition lapsed, restart
         fall_cnt_ff <= 6'h00;
         fall_evt_ff <= 1'b0;
      end else if (sample_tick) begin
         if (fall_cnt_ff >= fall_time)
            fall_evt_ff <= 1'b1;
         else
            fall_cnt_ff <= fall_cnt_ff + 6'h01;
      end
   end

   // wakeup duration: condition persists wakeup_time extra periods
   // a three-bit counter leaves room for the compare at the top setting
   always @(posedge clock) begin
      if (sys_rst) begin
         wake_cnt_ff <= 3'h0;
         wake_evt_ff <= 1'b0;
      end else if (!wake_cond) begin
         wake_cnt_ff <= 3'h0;
         wake_evt_ff <= 1'b0;
      end else if (sample_tick) begin
         if (wake_cnt_ff >= {1'b0, wakeup_time})
            wake_evt_ff <= 1'b1;
         else
            wake_cnt_ff <= wake_cnt_ff + 3'h1;
      end
   end

   // sleep entry: stillness for sleep_target periods enters sleep;
   // any motion leaves sleep at once
   // a change pulse marks both entry and exit, for change-mode routing
   // while asleep the counter is frozen, so leaving sleep restarts it
   always @(posedge clock) begin
      if (sys_rst) begin
         still_cnt_ff <= 13'h0000;
         asleep_ff    <= 1'b0;
         sleep_chg_ff <= 1'b0;
      end else begin
         sleep_chg_ff <= 1'b0;
         if (!still_cond) begin
            still_cnt_ff <= 13'h0000;
            if (asleep_ff) begin
               asleep_ff    <= 1'b0;
               sleep_chg_ff <= 1'b1;
            end
         end else if (sample_tick && !asleep_ff) begin
            // count saturates, so a long pause cannot wrap
            if (still_cnt_ff + 13'h0001 >= sleep_target) begin
               asleep_ff    <= 1'b1;
               sleep_chg_ff <= 1'b1;
            end else begin
               still_cnt_ff <= still_cnt_ff + 13'h0001;
            end
         end
      end
   end

   // threshold reports for the detectors
   // table lookups and products are registered to keep outputs on flops
   // the coarse step truncates fs/64 and the fine step fs/256;
   // the small rounding loss is traded for a shift instead of a divider
   always @(posedge clock) begin
      if (sys_rst) begin
         fall_level_mg_ff <= 9'h000;
         wake_level_mg_ff <= 16'h0000;
         ts_alert_ff      <= 1'b0;
      end else begin
         fall_level_mg_ff <= fall_mg(fall_level_code);
         // weight picks the step size of the wakeup level
         if (wakeup_level_weight)
            wake_level_mg_ff <= (fs_mg >> `MEIR_WK_SHIFT_FINE) * level_ext;
         else
            wake_level_mg_ff <= (fs_mg >> `MEIR_WK_SHIFT_COARSE) * level_ext;
         ts_alert_ff <= ts_near_wrap;
      end
   end

   // per-bit route gates: an event counts only where its route bit is set
   // the same gate serves every source, so one loop builds both pins
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_route
         assign p1_gated[gi] = p1_events[gi] & p1_route_ff[gi];
         assign p2_gated[gi] = p2_events[gi] & p2_route_ff[gi];
      end
   endgenerate

   // pin outputs: OR of events whose route bit is set
   // both pins are registered, so a pin follows its event one edge later
   // nothing is latched here: a pin falls one edge after its events do
   always @(posedge clock) begin
      if (sys_rst) begin
         irq_pin_one_ff <= 1'b0;
         irq_pin_two_ff <= 1'b0;
      end else begin
         irq_pin_one_ff <= |p1_gated;
         irq_pin_two_ff <= |p2_gated;
      end
   end

endmodule

// ---- test/meir_top_monitor.sv ----
// port-level checker for the motion event timing and routing block
// sees only meir_top ports; bound to every instance below
`timescale 1ns/1ps
module meir_top_mon (
   input wire        clock,
   input wire        sys_rst,
   input wire        reg_wr,
   input wire        reg_rd,
   input wire [7:0]  reg_addr,
   input wire [7:0]  reg_rdata_ff,
   input wire        reg_ack_ff,
   input wire        sample_tick,
   input wire        basic_irq_enable,
   input wire        fall_cond,
   input wire        wake_cond,
   input wire        still_cond,
   input wire        embedded_evt,
   input wire        hub_done_evt,
   input wire [31:0] ts_count,
   input wire        irq_pin_one_ff,
   input wire        irq_pin_two_ff,
   input wire        fall_evt_ff,
   input wire        wake_evt_ff,
   input wire        asleep_ff
);
   // one clock domain, so one default clock and reset
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   a_ack_after_access: assert property ((reg_wr || reg_rd) |=> reg_ack_ff)
      else $error("no ack after access");
   a_no_stray_ack: assert property (!(reg_wr || reg_rd) |=> !reg_ack_ff)
      else $error("ack without access");
   a_unmapped_reads_zero: assert property (
      reg_rd && reg_addr[7:2] != 6'h17 |=> reg_rdata_ff == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata_ff))
      else $error("read data moved without read");
   a_fall_clears: assert property (!fall_cond |=> !fall_evt_ff)
      else $error("fall event outlived its condition");
   a_fall_on_tick: assert property (
      $rose(fall_evt_ff) |-> $past(sample_tick) && $past(fall_cond))
      else $error("fall event off a sample");
   a_wake_on_tick: assert property (
      $rose(wake_evt_ff) |-> $past(sample_tick) && $past(wake_cond))
      else $error("wake event off a sample");
   a_sleep_leaves: assert property (!still_cond [*2] |=> !asleep_ff)
      else $error("still asleep after motion");
   a_pin_one_gated: assert property (
      (!basic_irq_enable && !embedded_evt && !hub_done_evt) [*2] |=> !irq_pin_one_ff)
      else $error("pin one high with basic events off");
   a_pin_two_gated: assert property (
      (!basic_irq_enable && !embedded_evt && ts_count < 32'hFFFB_1DFF) [*3]
      |=> !irq_pin_two_ff)
      else $error("pin two high with nothing routable");
   // main scenarios reached
   cover property ($rose(fall_evt_ff));
   cover property ($rose(asleep_ff));
   cover property ($rose(irq_pin_two_ff));
endmodule

bind meir_top meir_top_mon mon (.*);

// ---- test/meir_top_test.sv ----
// self-checking bench for meir_top: registers, durations, pin routing
// drives every input on the falling edge of a 50 MHz clock
`timescale 1ns/1ps
`include "meir_consts.vh"
module meir_top_test;
   reg         clock = 0;             // 50 MHz system clock
   reg         sys_rst = 1;           // sync reset, active high
   reg         reg_wr = 0, reg_rd = 0;
   reg  [7:0]  reg_addr = 0, reg_wdata = 0;
   reg         sample_tick = 0, basic_irq_enable = 0, sleep_status_on_irq = 0;
   reg  [5:0]  wakeup_level = 0;
   reg  [2:0]  cond = 0;              // still, wake, fall conditions
   reg  [4:0]  evt = 0;               // single, double, orient, embedded, hub
   reg  [31:0] ts_count = 0;
   reg  [15:0] w0;                    // coarse-weight wakeup level
   wire [7:0]  reg_rdata_ff;
   wire        reg_ack_ff, irq_pin_one_ff, irq_pin_two_ff;
   wire        fall_evt_ff, wake_evt_ff, asleep_ff;
   wire [2:0]  evt_bus = {asleep_ff, wake_evt_ff, fall_evt_ff};
   wire [8:0]  fall_level_mg_ff;
   wire [15:0] wake_level_mg_ff;
   wire [71:0] mgt = {9'h1F4, 9'h1D5, 9'h196, 9'h158, 9'h138, 9'h0FA, 9'h0DB, 9'h09C};
   wire [39:0] rmask = {8'h40, 8'h08, 8'h04, 8'h02, 8'h01};
   integer     num_errors = 0, compares = 0, i, b;

   always #10 clock = ~clock;

   meir_top uut (.clock(clock), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
      .reg_ack_ff(reg_ack_ff), .sample_tick(sample_tick),
      .basic_irq_enable(basic_irq_enable), .sleep_status_on_irq(sleep_status_on_irq),
      .wakeup_level(wakeup_level), .accel_full_scale(3'h0), .fall_cond(cond[0]),
      .wake_cond(cond[1]), .still_cond(cond[2]), .single_knock_evt(evt[4]),
      .double_knock_evt(evt[3]), .orientation_evt(evt[2]), .embedded_evt(evt[1]),
      .hub_done_evt(evt[0]), .ts_count(ts_count), .irq_pin_one_ff(irq_pin_one_ff),
      .irq_pin_two_ff(irq_pin_two_ff), .fall_evt_ff(fall_evt_ff),
      .wake_evt_ff(wake_evt_ff), .asleep_ff(asleep_ff),
      .fall_level_mg_ff(fall_level_mg_ff), .wake_level_mg_ff(wake_level_mg_ff));

   task finish_test;
      begin
         if (num_errors == 0 && compares > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask

   task chk(input [15:0] got, input [15:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask

   // one access; ack and read data are due exactly one edge later
   task acc(input w, input [7:0] a, input [7:0] d, input [7:0] exp);
      begin
         @(negedge clock);
         reg_wr = w;
         reg_rd = !w;
         reg_addr = a;
         reg_wdata = d;
         @(negedge clock);
         reg_wr = 0;
         reg_rd = 0;
         chk(reg_ack_ff, 1);
         if (!w) chk(reg_rdata_ff, exp);
      end
   endtask

   task ticks(input integer n);
      repeat (n) begin
         @(negedge clock) sample_tick = 1;
         @(negedge clock) sample_tick = 0;
      end
   endtask

   // hold condition k: event must wait for tick n, then reach pin one
   task timed(input integer k, input integer n, input [7:0] route);
      begin
         acc(1, `MEIR_ADDR_P1, route, 0);
         cond[k] = 1;
         ticks(n - 1);
         chk(evt_bus[k], 0);
         ticks(1);
         chk(evt_bus[k], 1);
         @(negedge clock);
         chk(irq_pin_one_ff, 1);
         cond[k] = 0;
         repeat (3) @(negedge clock);
         chk(evt_bus[k], 0);
      end
   endtask

   // hang guard: far beyond the longest sequence
   initial begin
      #1000000;
      num_errors = num_errors + 1;
      finish_test;
   end

   initial begin
      repeat (6) @(negedge clock);
      sys_rst = 0;
      for (i = 0; i < 4; i = i + 1)
         acc(0, `MEIR_ADDR_DUR + i[7:0], 0, 0);
      for (b = 0; b < 8; b = b + 1)
         acc(b < 4, `MEIR_ADDR_DUR + b[1:0], 8'hA4 + b[1:0], 8'hA4 + b[1:0]);
      acc(1, 8'h60, 8'hFF, 0);
      acc(0, 8'h60, 0, 0);
      for (i = 0; i < 8; i = i + 1) begin
         acc(1, `MEIR_ADDR_FALL, i[7:0], 0);
         acc(0, `MEIR_ADDR_FALL, 0, i[7:0]);
         chk(fall_level_mg_ff, mgt[i*9 +: 9]);
      end
      // coarse weight must give the larger level per count
      wakeup_level = 6'h10;
      acc(1, `MEIR_ADDR_DUR, 8'h00, 0);
      repeat (2) @(negedge clock);
      w0 = wake_level_mg_ff;
      acc(1, `MEIR_ADDR_DUR, 8'h10, 0);
      repeat (2) @(negedge clock);
      chk(w0 > wake_level_mg_ff, 1);
      basic_irq_enable = 1;
      sleep_status_on_irq = 1;
      acc(1, `MEIR_ADDR_DUR, 8'h80, 0);
      acc(1, `MEIR_ADDR_FALL, 8'h08, 0);
      timed(0, 34, 8'h10);
      acc(1, `MEIR_ADDR_DUR, 8'h60, 0);
      timed(1, 4, 8'h20);
      acc(1, `MEIR_ADDR_DUR, 8'h00, 0);
      timed(2, 16, 8'h80);
      acc(1, `MEIR_ADDR_DUR, 8'h01, 0);
      timed(2, 512, 8'h80);
      // change mode: pin one pulses once as sleep is entered
      sleep_status_on_irq = 0;
      acc(1, `MEIR_ADDR_DUR, 8'h00, 0);
      acc(1, `MEIR_ADDR_P1, 8'h80, 0);
      cond[2] = 1;
      ticks(16);
      @(negedge clock);
      chk(irq_pin_one_ff, 1);
      @(negedge clock);
      chk(irq_pin_one_ff, 0);
      cond[2] = 0;
      repeat (3) @(negedge clock);
      for (b = 0; b < 2; b = b + 1) begin
         basic_irq_enable = b[0];
         for (i = 0; i < 5; i = i + 1) begin
            acc(1, `MEIR_ADDR_P1, rmask[i*8 +: 8], 0);
            acc(1, `MEIR_ADDR_P2, rmask[i*8 +: 8], 0);
            evt[i] = 1;
            repeat (2) @(negedge clock);
            chk(irq_pin_one_ff, b[0] || i < 2);
            chk(irq_pin_two_ff, (b[0] || i < 2) && i > 0);
            acc(1, `MEIR_ADDR_P1, ~rmask[i*8 +: 8], 0);
            repeat (2) @(negedge clock);
            chk(irq_pin_one_ff, 0);
            evt[i] = 0;
         end
      end
      acc(1, `MEIR_ADDR_P2, 8'h01, 0);
      ts_count = 32'hFFFB_1DFE;
      repeat (4) @(negedge clock);
      chk(irq_pin_two_ff, 0);
      ts_count = 32'hFFFB_1DFF;
      repeat (3) @(negedge clock);
      chk(irq_pin_two_ff, 1);
      finish_test;
   end
endmodule
